// *** logic/endpoint_buffer_map.sv ***
// Purpose: Register file and buffer address map for endpoints 1-3 and 5-7.
// Assumes: APB slave, zero wait states beyond one registered access cycle.
// Notes:   Packet engine asks for addresses and reports finished packets.

`timescale 1ns/10ps

module endpoint_buffer_map (
	// Clock and reset
	input  logic        clock,
	input  logic        rst_b,
	// APB slave
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [11:0] paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	// Buffer address request from the packet engine
	input  logic        req_valid,
	input  logic [2:0]  req_ep,
	input  logic        req_tx,
	input  logic [5:0]  req_idx,
	output logic [15:0] buf_addr,
	output logic        buf_ack,
	output logic        buf_refused,
	output logic [6:0]  tx_count,
	// Packet completion from the packet engine
	input  logic        done_valid,
	input  logic [2:0]  done_ep,
	input  logic        done_tx,
	// Host mode token
	output logic        host_pid3
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic ep_ok(input logic [2:0] n);
		return (n != 3'h0) && (n != 3'h4);
	endfunction : ep_ok

	// Returns {rx, tx, dbl}; endpoints 5-7 never report double mode.
	function automatic logic [2:0] ep_mode(input logic [2:0] n, input logic [8:0] m123,
		input logic [5:0] m567);
		case (n)
			3'h1: ep_mode = m123[2:0];
			3'h2: ep_mode = m123[5:3];
			3'h3: ep_mode = m123[8:6];
			3'h5: ep_mode = {m567[1:0], 1'b0};
			3'h6: ep_mode = {m567[3:2], 1'b0};
			3'h7: ep_mode = {m567[5:4], 1'b0};
			default: ep_mode = 3'h0;
		endcase
	endfunction : ep_mode

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [8:0]  mod123_q;
	logic [8:0]  mod123_d;
	logic [5:0]  mod567_q;
	logic [5:0]  mod567_d;
	logic [15:0] dma_q [8];
	logic [15:0] dma_d [8];
	logic [6:0]  len_q [8];
	logic [6:0]  len_d [8];
	logic [7:0]  rtog_q;
	logic [7:0]  rtog_d;
	logic [7:0]  ttog_q;
	logic [7:0]  ttog_d;
	logic [7:0]  auto_q;
	logic [7:0]  auto_d;
	logic        pid3_q;
	logic        pid3_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic        pready_q;
	logic        pready_d;
	logic        pslverr_q;
	logic        pslverr_d;
	logic [6:0]  txc_q;
	logic [6:0]  txc_d;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	logic        setup;
	logic        wr;
	logic [2:0]  a_ep;
	logic [3:0]  a_sub;
	logic        hit_ep;
	logic        hit;
	logic [31:0] rd;

	assign setup  = psel && !penable;
	assign wr     = psel && penable && pready_q && pwrite && !pslverr_q;
	assign a_ep   = paddr[6:4];
	assign a_sub  = paddr[3:0];
	assign hit_ep = (paddr[11:7] == 5'h00) && ep_ok(a_ep)
		&& (a_sub == ebm_pkg::EP_DMA_SUB || a_sub == ebm_pkg::EP_LEN_SUB
		|| a_sub == ebm_pkg::EP_CTRL_SUB);
	assign hit    = hit_ep || paddr == ebm_pkg::MOD123_ADDR
		|| paddr == ebm_pkg::MOD567_ADDR;

	always_comb begin
		rd = 32'h0000_0000;
		if (paddr == ebm_pkg::MOD123_ADDR) begin
			rd[8:0] = mod123_q;
		end else if (paddr == ebm_pkg::MOD567_ADDR) begin
			rd[5:0] = mod567_q;
		end else if (hit_ep && a_sub == ebm_pkg::EP_DMA_SUB) begin
			rd[15:0] = dma_q[a_ep];
		end else if (hit_ep && a_sub == ebm_pkg::EP_LEN_SUB) begin
			rd[6:0] = len_q[a_ep];
			rd[ebm_pkg::LEN_PID3] = (a_ep == ebm_pkg::EP_PID3) && pid3_q;
		end else if (hit_ep) begin
			rd[ebm_pkg::CTRL_RTOG] = rtog_q[a_ep];
			rd[ebm_pkg::CTRL_TTOG] = ttog_q[a_ep];
			rd[ebm_pkg::CTRL_AUTO] = auto_q[a_ep];
		end
	end

	always_comb begin
		pready_d  = setup;
		pslverr_d = setup && !hit;
		prdata_d  = setup ? rd : prdata_q;
	end

	// ---------------------------------------------------------------
	// Endpoint configuration for the current request
	// ---------------------------------------------------------------
	ep_cfg_if cfg ();
	logic [2:0]  sel_mode;

	assign sel_mode   = ep_mode(req_ep, mod123_q, mod567_q);
	assign cfg.rx_en  = sel_mode[ebm_pkg::MOD_RX];
	assign cfg.tx_en  = sel_mode[ebm_pkg::MOD_TX];
	assign cfg.dbl    = sel_mode[ebm_pkg::MOD_DBL];
	assign cfg.r_tog  = rtog_q[req_ep];
	assign cfg.t_tog  = ttog_q[req_ep];
	assign cfg.dir_tx = req_tx;

	ep_mode_decode u_decode (
		.cfg (cfg.dec)
	);

	buf_addr_gen u_addr (
		.clock     (clock),
		.rst_b     (rst_b),
		.req_valid (req_valid),
		.start     (dma_q[req_ep]),
		.idx       (req_idx),
		.cfg       (cfg.use_),
		.addr_q    (buf_addr),
		.ack_q     (buf_ack),
		.refused_q (buf_refused)
	);

	// ---------------------------------------------------------------
	// Register updates
	// ---------------------------------------------------------------
	// A write and a finished packet in one cycle both count: the flip is
	// applied on top of the written value so no packet is lost.
	always_comb begin
		mod123_d = mod123_q;
		mod567_d = mod567_q;
		dma_d    = dma_q;
		len_d    = len_q;
		rtog_d   = rtog_q;
		ttog_d   = ttog_q;
		auto_d   = auto_q;
		pid3_d   = pid3_q;
		txc_d    = txc_q;
		if (wr && paddr == ebm_pkg::MOD123_ADDR) begin
			mod123_d = pwdata[8:0];
		end
		if (wr && paddr == ebm_pkg::MOD567_ADDR) begin
			mod567_d = pwdata[5:0];
		end
		if (wr && hit_ep && a_sub == ebm_pkg::EP_DMA_SUB) begin
			dma_d[a_ep] = pwdata[15:0];
		end
		if (wr && hit_ep && a_sub == ebm_pkg::EP_LEN_SUB) begin
			len_d[a_ep] = pwdata[6:0];
			if (a_ep == ebm_pkg::EP_PID3) begin
				pid3_d = pwdata[ebm_pkg::LEN_PID3];
			end
		end
		if (wr && hit_ep && a_sub == ebm_pkg::EP_CTRL_SUB) begin
			rtog_d[a_ep] = pwdata[ebm_pkg::CTRL_RTOG];
			ttog_d[a_ep] = pwdata[ebm_pkg::CTRL_TTOG];
			auto_d[a_ep] = pwdata[ebm_pkg::CTRL_AUTO];
		end
		if (done_valid && ep_ok(done_ep) && auto_q[done_ep]) begin
			if (done_tx) begin
				ttog_d[done_ep] = !ttog_d[done_ep];
			end else begin
				rtog_d[done_ep] = !rtog_d[done_ep];
			end
		end
		if (req_valid && req_tx) begin
			txc_d = len_q[req_ep];
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mod123_q  <= ebm_pkg::MOD123_RST;
			mod567_q  <= ebm_pkg::MOD567_RST;
			dma_q     <= '{default: ebm_pkg::DMA_RST};
			len_q     <= '{default: ebm_pkg::LEN_RST};
			rtog_q    <= {8{ebm_pkg::TOG_RST}};
			ttog_q    <= {8{ebm_pkg::TOG_RST}};
			auto_q    <= 8'h00;
			pid3_q    <= ebm_pkg::PID3_RST;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			txc_q     <= ebm_pkg::LEN_RST;
		end else begin
			mod123_q  <= mod123_d;
			mod567_q  <= mod567_d;
			dma_q     <= dma_d;
			len_q     <= len_d;
			rtog_q    <= rtog_d;
			ttog_q    <= ttog_d;
			auto_q    <= auto_d;
			pid3_q    <= pid3_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			txc_q     <= txc_d;
		end
	end

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign tx_count  = txc_q;
	assign host_pid3 = pid3_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	ready_timing_a: assert property (@(posedge clock) disable iff (!rst_b)
		setup |=> pready ##1 !pready)
		else $error("APB ready is not a single cycle after setup");
	unmapped_err_a: assert property (@(posedge clock) disable iff (!rst_b)
		setup && !hit |=> pslverr && pready)
		else $error("unmapped address did not raise pslverr");
	rx_flip_a: assert property (@(posedge clock) disable iff (!rst_b)
		done_valid && !done_tx && ep_ok(done_ep) && auto_q[done_ep] && !wr
		|=> rtog_q[$past(done_ep)] != $past(rtog_q[done_ep]))
		else $error("receive toggle did not flip after a good packet");
	tx_flip_a: assert property (@(posedge clock) disable iff (!rst_b)
		done_valid && done_tx && ep_ok(done_ep) && auto_q[done_ep] && !wr
		|=> ttog_q[$past(done_ep)] != $past(ttog_q[done_ep]))
		else $error("transmit toggle did not flip after a good packet");
	tog_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
		!wr && !done_valid |=> $stable(rtog_q) && $stable(ttog_q))
		else $error("toggle changed with no cause");
	len_rsvd_a: assert property (@(posedge clock) disable iff (!rst_b)
		setup && hit_ep && a_sub == ebm_pkg::EP_LEN_SUB && a_ep != ebm_pkg::EP_PID3
		|=> prdata[7] == 1'b0)
		else $error("transmit length bit 7 read as one");
	mod567_rsvd_a: assert property (@(posedge clock) disable iff (!rst_b)
		pready && !pslverr |-> !(($past(paddr) == ebm_pkg::MOD567_ADDR) && |prdata[7:6]))
		else $error("upper mode reserved bits read as one");
	dbl_mask_a: assert property (@(posedge clock) disable iff (!rst_b)
		req_valid && req_ep > 3'h4 && !cfg.blocked
		|-> cfg.offset == ((req_tx && cfg.rx_en) ? ebm_pkg::OFS_HALF : ebm_pkg::OFS_ZERO))
		else $error("endpoints 5 to 7 left single buffering");
	txc_load_a: assert property (@(posedge clock) disable iff (!rst_b)
		req_valid && req_tx |=> tx_count == $past(len_q[req_ep]))
		else $error("transmit count not loaded for IN request");
endmodule : endpoint_buffer_map

// *** logic/ebm_pkg.sv ***
// Purpose: Shared constants for the endpoint buffer map block.
// Assumes: APB with 32-bit data and 12-bit byte addresses.
// Notes:   Each register takes one aligned word.

package ebm_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [11:0] MOD123_ADDR  = 12'h000;
	localparam logic [11:0] MOD567_ADDR  = 12'h004;
	localparam logic [3:0]  EP_DMA_SUB   = 4'h0;
	localparam logic [3:0]  EP_LEN_SUB   = 4'h4;
	localparam logic [3:0]  EP_CTRL_SUB  = 4'h8;
	localparam logic [2:0]  EP_PID3      = 3'h2;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int          MOD_RX       = 2;
	localparam int          MOD_TX       = 1;
	localparam int          MOD_DBL      = 0;
	localparam int          M567_RX      = 1;
	localparam int          M567_TX      = 0;
	localparam int          CTRL_RTOG    = 7;
	localparam int          CTRL_TTOG    = 6;
	localparam int          CTRL_AUTO    = 4;
	localparam int          LEN_PID3     = 7;

	// ---------------------------------------------------------------
	// Reset values and buffer offsets
	// ---------------------------------------------------------------
	localparam logic [8:0]  MOD123_RST   = 9'h000;
	localparam logic [5:0]  MOD567_RST   = 6'h00;
	localparam logic [15:0] DMA_RST      = 16'h0000;
	localparam logic [6:0]  LEN_RST      = 7'h00;
	localparam logic        PID3_RST     = 1'b0;
	localparam logic        TOG_RST      = 1'b0;
	localparam logic [7:0]  OFS_ZERO     = 8'h00;
	localparam logic [7:0]  OFS_HALF     = 8'h40;
	localparam logic [7:0]  OFS_TX_DBL   = 8'h80;
endpackage : ebm_pkg

// *** logic/ep_cfg_if.sv ***
// Purpose: Carries one endpoint's selected mode into the decoder and offset out.
// Assumes: Driven combinationally from the register file.
// Notes:   No clocking block; plain nets only.

`timescale 1ns/10ps

interface ep_cfg_if;
	logic       rx_en;
	logic       tx_en;
	logic       dbl;
	logic       r_tog;
	logic       t_tog;
	logic       dir_tx;
	logic       blocked;
	logic [7:0] offset;

	modport src (output rx_en, tx_en, dbl, r_tog, t_tog, dir_tx);
	modport dec (input rx_en, tx_en, dbl, r_tog, t_tog, dir_tx, output blocked, offset);
	modport use_ (input blocked, offset);
endinterface : ep_cfg_if

// *** logic/ep_mode_decode.sv ***
// Purpose: Turns enables, buffer mode and toggles into a buffer offset.
// Assumes: Double mode is already masked off for endpoints without it.
// Notes:   Purely combinational.

`timescale 1ns/10ps

module ep_mode_decode (
	// Mode in, offset out
	ep_cfg_if.dec cfg
);
	always_comb begin
		cfg.blocked = 1'b0;
		cfg.offset  = ebm_pkg::OFS_ZERO;
		if (!cfg.rx_en && !cfg.tx_en) begin
			cfg.blocked = 1'b1;
		end else if (cfg.dir_tx) begin
			if (!cfg.tx_en) begin
				cfg.blocked = 1'b1;
			end else if (cfg.rx_en && cfg.dbl) begin
				cfg.offset = cfg.t_tog ? (ebm_pkg::OFS_TX_DBL | ebm_pkg::OFS_HALF)
					: ebm_pkg::OFS_TX_DBL;
			end else if (cfg.rx_en) begin
				cfg.offset = ebm_pkg::OFS_HALF;
			end else if (cfg.dbl && cfg.t_tog) begin
				cfg.offset = ebm_pkg::OFS_HALF;
			end
		end else begin
			if (!cfg.rx_en) begin
				cfg.blocked = 1'b1;
			end else if (cfg.dbl && cfg.r_tog) begin
				cfg.offset = ebm_pkg::OFS_HALF;
			end
		end
	end
endmodule : ep_mode_decode

// *** logic/buf_addr_gen.sv ***
// Purpose: Registers the buffer access address for one request.
// Assumes: Offset and blocked settle within the request cycle.
// Notes:   Answer comes one cycle after the request.

`timescale 1ns/10ps

module buf_addr_gen (
	// Clock and reset
	input  logic        clock,
	input  logic        rst_b,
	// Request
	input  logic        req_valid,
	input  logic [15:0] start,
	input  logic [5:0]  idx,
	ep_cfg_if.use_      cfg,
	// Answer
	output logic [15:0] addr_q,
	output logic        ack_q,
	output logic        refused_q
);
	logic [15:0] addr_d;
	logic        ack_d;
	logic        refused_d;

	always_comb begin
		addr_d    = addr_q;
		ack_d     = req_valid && !cfg.blocked;
		refused_d = req_valid && cfg.blocked;
		if (ack_d) begin
			addr_d = 16'(start + {8'h00, cfg.offset} + {10'h000, idx});
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			addr_q    <= 16'h0000;
			ack_q     <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			addr_q    <= addr_d;
			ack_q     <= ack_d;
			refused_q <= refused_d;
		end
	end

	addr_sum_a: assert property (@(posedge clock) disable iff (!rst_b)
		ack_q |-> addr_q == 16'($past(start) + {8'h00, $past(cfg.offset)}
			+ {10'h000, $past(idx)}))
		else $error("buffer address is not start plus offset plus index");
	refuse_blocked_a: assert property (@(posedge clock) disable iff (!rst_b)
		req_valid && cfg.blocked |=> refused_q && !ack_q)
		else $error("blocked endpoint was not refused");
	answer_once_a: assert property (@(posedge clock) disable iff (!rst_b)
		!req_valid |=> !ack_q && !refused_q)
		else $error("answer without a request");
endmodule : buf_addr_gen

// *** verif/pkt_engine_model.sv ***
// Purpose: Packet engine model that asks for buffer addresses and reports packets.
// Assumes: Every request is launched just after a rising clock edge.
// Notes:   Idle fields are inverted so that a stale value is never reused.

`timescale 1ns/10ps

module pkt_engine_model (
	// Clock
	input  logic       clock,
	// Address requests
	output logic       req_valid,
	output logic [2:0] req_ep,
	output logic       req_tx,
	output logic [5:0] req_idx,
	// Packet completions
	output logic       done_valid,
	output logic [2:0] done_ep,
	output logic       done_tx
);
	initial begin
		req_valid = 1'b0;
		req_ep = 3'h0;
		req_tx = 1'b0;
		req_idx = 6'h00;
		done_valid = 1'b0;
		done_ep = 3'h0;
		done_tx = 1'b0;
	end

	// A gap of zero still leaves one idle cycle between requests; larger gaps model a slow engine.
	task automatic request(input logic [2:0] ep, input logic tx, input logic [5:0] idx,
		input int gap);
		repeat (gap) @(posedge clock);
		@(posedge clock);
		req_valid <= 1'b1;
		req_ep <= ep;
		req_tx <= tx;
		req_idx <= idx;
		@(posedge clock);
		req_valid <= 1'b0;
		req_ep <= ~ep;
		req_tx <= ~tx;
		req_idx <= ~idx;
	endtask : request

	task automatic finish(input logic [2:0] ep, input logic tx);
		@(posedge clock);
		done_valid <= 1'b1;
		done_ep <= ep;
		done_tx <= tx;
		@(posedge clock);
		done_valid <= 1'b0;
		done_ep <= ~ep;
		done_tx <= ~tx;
	endtask : finish
endmodule : pkt_engine_model

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for the endpoint buffer map.
// Assumes: APB answers one cycle after setup; addresses answer one cycle later.
// Notes:   Drivers queue expectations; monitors pop them when results appear.

`timescale 1ns/10ps

module testbench;
	typedef struct packed {
		logic [31:0] data;
		logic        err;
		logic        rd;
	} apb_exp_t;
	typedef struct packed {
		logic [15:0] addr;
		logic        refused;
		logic        tx;
		logic [6:0]  count;
	} buf_exp_t;

	logic        clock;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        req_valid;
	logic [2:0]  req_ep;
	logic        req_tx;
	logic [5:0]  req_idx;
	logic [15:0] buf_addr;
	logic        buf_ack;
	logic        buf_refused;
	logic [6:0]  tx_count;
	logic        done_valid;
	logic [2:0]  done_ep;
	logic        done_tx;
	logic        host_pid3;
	int          fail_count;
	int          cmp_count;
	integer      seed;
	apb_exp_t    apb_q[$];
	buf_exp_t    buf_q[$];
	apb_exp_t    ae;
	buf_exp_t    be;
	logic [2:0]  eps[6] = '{3'd1, 3'd2, 3'd3, 3'd5, 3'd6, 3'd7};

	endpoint_buffer_map dut_u (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .req_valid, .req_ep, .req_tx, .req_idx, .buf_addr,
		.buf_ack, .buf_refused, .tx_count, .done_valid, .done_ep, .done_tx, .host_pid3);
	pkt_engine_model model_u (.clock, .req_valid, .req_ep, .req_tx, .req_idx, .done_valid,
		.done_ep, .done_tx);

	initial clock = 1'b0;
	always #12.5 clock = ~clock;

	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	always @(posedge clock) begin
		if (pready === 1'b1) begin
			check(apb_q.size() > 0, 1, "unexpected ready");
			ae = apb_q.pop_front();
			check(pslverr, ae.err, "slave error");
			if (ae.rd)
				check(prdata, ae.data, "read data");
		end
		if (buf_ack === 1'b1 || buf_refused === 1'b1) begin
			check(buf_q.size() > 0, 1, "unexpected answer");
			be = buf_q.pop_front();
			check({buf_refused, buf_ack}, {be.refused, !be.refused}, "answer kind");
			if (!be.refused)
				check(buf_addr, be.addr, "buffer address");
			if (!be.refused && be.tx)
				check(tx_count, be.count, "byte count");
		end
	end

	// ---------------------------------------------------------------
	// Drivers
	// ---------------------------------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		input logic [31:0] exp, input logic err);
		int n;
		apb_q.push_back('{exp, err, !wr});
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			print_verdict();
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	function automatic logic [8:0] exp_off(input logic [2:0] ep, input logic [2:0] m,
		input logic rt, input logic tt, input logic tx);
		logic d;
		d = m[0] && ep < 3'd4;
		if ((tx && !m[1]) || (!tx && !m[2]))
			return 9'h100;
		if (!tx)
			return (d && rt) ? 9'h040 : 9'h000;
		if (m[2])
			return d ? (tt ? 9'h0C0 : 9'h080) : 9'h040;
		return (d && tt) ? 9'h040 : 9'h000;
	endfunction : exp_off

	task automatic run_mode(input logic [2:0] ep, input logic [2:0] m);
		logic [15:0] st;
		logic [11:0] base;
		logic [6:0]  len;
		logic [5:0]  idx;
		logic [8:0]  off;
		logic        rt;
		logic        tt;
		st = 16'($random(seed)) & 16'hFFFC;
		len = 7'($random(seed));
		rt = 1'($random(seed));
		tt = 1'($random(seed));
		base = {5'h00, ep, 4'h0};
		apb(1'b1, base, {16'h0000, st}, 32'h0, 1'b0);
		apb(1'b1, base + 12'h004, {25'h0, len}, 32'h0, 1'b0);
		apb(1'b1, base + 12'h008, {24'h0, rt, tt, 6'h00}, 32'h0, 1'b0);
		if (ep < 3'd4)
			apb(1'b1, ebm_pkg::MOD123_ADDR, 32'(m) << (3 * (ep - 1)), 32'h0, 1'b0);
		else
			apb(1'b1, ebm_pkg::MOD567_ADDR, 32'(m[2:1]) << (2 * (ep - 5)), 32'h0, 1'b0);
		// each receive buffer spans 64 bytes
		for (int t = 0; t < 2; t++) begin
			idx = 6'($random(seed));
			off = exp_off(ep, m, rt, tt, t[0]);
			buf_q.push_back('{st + {8'h00, off[7:0]} + {10'h000, idx}, off[8], t[0], len});
			model_u.request(ep, t[0], idx, t);
		end
	endtask : run_mode

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		seed = 32'hA6B13DE0;
		fail_count = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		apb(1'b0, ebm_pkg::MOD123_ADDR, 32'h0, 32'h0, 1'b0);
		apb(1'b0, ebm_pkg::MOD567_ADDR, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 12'h024, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 12'h040, 32'h0, 32'h0, 1'b1);
		apb(1'b1, ebm_pkg::MOD567_ADDR, 32'hFFFFFFFF, 32'h0, 1'b0);
		apb(1'b0, ebm_pkg::MOD567_ADDR, 32'h0, 32'h3F, 1'b0);
		apb(1'b1, 12'h014, 32'hFF, 32'h0, 1'b0);
		apb(1'b0, 12'h014, 32'h0, 32'h7F, 1'b0);
		apb(1'b1, 12'h024, 32'hFF, 32'h0, 1'b0);
		apb(1'b0, 12'h024, 32'h0, 32'hFF, 1'b0);
		#1 check(host_pid3, 1, "pid bit set");
		apb(1'b1, 12'h024, 32'h05, 32'h0, 1'b0);
		#1 check(host_pid3, 0, "pid bit clear");
		foreach (eps[i])
			for (int m = 0; m < 8; m++)
				run_mode(eps[i], m[2:0]);
		buf_q.push_back('{16'h0, 1'b1, 1'b0, 7'h0});
		model_u.request(3'd4, 1'b0, 6'h01, 0);
		buf_q.push_back('{16'h0, 1'b1, 1'b1, 7'h0});
		model_u.request(3'd0, 1'b1, 6'h02, 0);
		apb(1'b1, 12'h010, 32'h1000, 32'h0, 1'b0);
		apb(1'b1, 12'h014, 32'h23, 32'h0, 1'b0);
		apb(1'b1, ebm_pkg::MOD123_ADDR, 32'h7, 32'h0, 1'b0);
		apb(1'b1, 12'h018, 32'h10, 32'h0, 1'b0);
		apb(1'b1, 12'h028, 32'h00, 32'h0, 1'b0);
		model_u.finish(3'd1, 1'b0);
		model_u.finish(3'd1, 1'b1);
		model_u.finish(3'd2, 1'b0);
		apb(1'b0, 12'h018, 32'h0, 32'hD0, 1'b0);
		apb(1'b0, 12'h028, 32'h0, 32'h0, 1'b0);
		buf_q.push_back('{16'h1045, 1'b0, 1'b0, 7'h23});
		model_u.request(3'd1, 1'b0, 6'h05, 0);
		buf_q.push_back('{16'h10C6, 1'b0, 1'b1, 7'h23});
		model_u.request(3'd1, 1'b1, 6'h06, 0);
		for (int n = 0; n < 20 && buf_q.size() > 0; n++)
			@(posedge clock);
		check(buf_q.size() + apb_q.size(), 0, "answers missing");
		print_verdict();
	end
endmodule : testbench
